// file: core/fss_cfg.svh
// Register map, field positions, reset values and sizes of the parameter sequencer.
// Included by the package, the sequencer, the assertions and the testbench; definitions only.
`ifndef FSS_CFG_SVH
`define FSS_CFG_SVH

`define FSS_ADDR_W 8
`define FSS_SET_NUM 16
`define FSS_PARAM_NUM 7
`define FSS_BRANCH_NUM 2

`define FSS_OFS_CTRL 8'h00
`define FSS_OFS_PARAM_SEL 8'h04
`define FSS_OFS_PARAM_EN 8'h08
`define FSS_OFS_SET_SEL 8'h0c
`define FSS_OFS_CMD 8'h10
`define FSS_OFS_LIVE_SET 8'h14
`define FSS_OFS_FIRST_SET 8'h18
`define FSS_OFS_BRANCH_SEL 8'h1c
`define FSS_OFS_BRANCH_TGT 8'h20
`define FSS_OFS_BRANCH_SRC 8'h24
`define FSS_OFS_BRANCH_EDGE 8'h28
`define FSS_OFS_LIVE_VALUE 8'h2c

`define FSS_CTRL_ENGINE_BIT 0
`define FSS_CTRL_SETUP_BIT 1
`define FSS_CMD_STORE_BIT 0
`define FSS_CMD_RESTORE_BIT 1

`define FSS_RST_FIRST_SET 4'h0
`define FSS_RST_SET_SEL 4'h0
`define FSS_RST_PARAM_EN 7'h00
`define FSS_EDGE_UP_CODE 32'h0000_0000

`endif

// file: core/fss_pkg.sv
// Types of the parameter sequencer: parameter words, stored sets, branches, state.
// Sizes come from fss_cfg.svh.
`include "fss_cfg.svh"

package fss_pkg;

  typedef logic [15:0] fss_word_t;
  typedef fss_word_t [`FSS_PARAM_NUM-1:0] fss_params_t;

  // Parameter slots of a set
  typedef enum logic [2:0] {
    PAR_EXPOSURE = 3'h0,
    PAR_COUNT0 = 3'h1,
    PAR_ROI_H = 3'h2,
    PAR_ROI_V = 3'h3,
    PAR_GAIN = 3'h4,
    PAR_LENS_CUR = 3'h5,
    PAR_LENS_PWR = 3'h6
  } fss_param_e;

  // Branch trigger sources
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_EXPOSURE = 3'h1,
    SRC_COUNT0 = 3'h2,
    SRC_TIMER0 = 3'h3,
    SRC_ENCODER = 3'h4
  } fss_src_e;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } fss_engine_e;

  typedef struct packed {
    logic [3:0] target;
    fss_src_e src;
  } fss_branch_s;

  typedef struct packed {
    fss_params_t vals;
    fss_branch_s [`FSS_BRANCH_NUM-1:0] br;
  } fss_set_s;

  typedef struct packed {
    fss_set_s [`FSS_SET_NUM-1:0] sets;
    fss_params_t live;
    logic [`FSS_PARAM_NUM-1:0] param_en;
    logic [2:0] param_sel;
    logic [3:0] set_sel;
    logic [3:0] live_set;
    logic [3:0] first_set;
    logic branch_sel;
    logic engine_on;
    logic setup_mode;
    fss_engine_e eng;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] evt_level;
    logic [31:0] rdata;
  } fss_state_s;

endpackage : fss_pkg

// file: core/fss_sequencer.sv
// Parameter sequencer: sixteen stored parameter sets stepped by event edges.
// Assumes a plain register port with read data one cycle after the read strobe,
// and event inputs that may come from any clock domain.
// Outputs are fields of one state register; the port never makes the master wait.
//
// Operation
// - Sixteen stored parameter sets, addressed by a software chosen set index.
// - Set index picks the set for store, restore and branch settings.
// - Selector picks a parameter; its enable applies across all stored sets.
// - Store command copies live parameters into the indexed set.
// - Restore command copies the enabled parameters of the indexed set into the live parameters.
// - Two branches per set; branch selector picks which one is edited.
// - Each branch has trigger and target; on trigger target set goes live.
// - Both branches firing together: branch 0 wins, branch 1 ignored.
// - Trigger activation fixed to rising edge; other selections ignored.
// - A branch with trigger source off never causes a transition.
// - Sources: exposure end, counter 0 end, timer 0 end, encoder, rising edges.
// - Read-only register reports the live set index.
// - Read-write first set index names the set entered at start.
// - Engine switch turns sequencing on or off; steps only while on.
// - Once on, stepping runs without software action.
// - Counter length parameter applies only to counter 0.
// - Sequencer program is kept for the saved configurations; this design saves none, and reset clears every set.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fss_cfg.svh"

module fss_sequencer
  import fss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`FSS_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic exposure_done_evt,
  input wire logic count_unit0_done_evt,
  input wire logic timer_unit0_done_evt,
  input wire logic shaft_encoder_evt,
  output logic [15:0] exposure_length,
  output logic [15:0] count_unit0_length,
  output logic [15:0] roi_horiz_shift,
  output logic [15:0] roi_vert_shift,
  output logic [15:0] gain,
  output logic [15:0] lens_drive_current,
  output logic [15:0] lens_optical_power,
  output logic [3:0] live_set_index,
  output logic seq_engine_on,
  output logic seq_setup_mode
);

  // Sixteen sets live in the state register, indexed by set number
  fss_state_s st;
  fss_state_s next_st;
  logic [3:0] evt_edge;
  logic [3:0] evt_in;

  // Bit order follows the source codes minus one
  assign evt_in = {shaft_encoder_evt, timer_unit0_done_evt, count_unit0_done_evt, exposure_done_evt};

  // Maps a branch source to its detected edge; off never fires
  function automatic logic src_fired(input fss_src_e src, input logic [3:0] edges);
    logic hit;
    hit = 1'b0;
    case (src)
      SRC_EXPOSURE: hit = edges[0];
      SRC_COUNT0: hit = edges[1];
      SRC_TIMER0: hit = edges[2];
      SRC_ENCODER: hit = edges[3];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : src_fired

  // Copies enabled parameters of a stored set over the live ones
  function automatic fss_params_t apply_set(input fss_params_t live, input fss_params_t vals,
                                            input logic [`FSS_PARAM_NUM-1:0] en);
    fss_params_t res;
    res = live;
    for (int p = 0; p < `FSS_PARAM_NUM; p++) begin
      if (en[p]) begin
        res[p] = vals[p];
      end
    end
    return res;
  endfunction : apply_set

  generate
    for (genvar i = 0; i < 4; i++) begin : g_edge
      assign evt_edge[i] = (st.sync2[i] == st.sync3[i]) && st.sync3[i] && !st.evt_level[i];
    end
  endgenerate

  always_comb begin
    logic hit0;
    logic hit1;
    logic [3:0] tgt;
    fss_branch_s b0;
    fss_branch_s b1;
    next_st = st;
    hit0 = 1'b0;
    hit1 = 1'b0;
    tgt = 4'h0;
    b0 = st.sets[st.live_set].br[0];
    b1 = st.sets[st.live_set].br[1];

    // Three-flop synchroniser
    // A level counts only once stages two and three agree
    next_st.sync1 = evt_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 4; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.evt_level[i] = st.sync3[i];
      end
    end

    if (wr) begin
      case (addr)
        `FSS_OFS_CTRL: begin
          next_st.engine_on = wdata[`FSS_CTRL_ENGINE_BIT];
          next_st.setup_mode = wdata[`FSS_CTRL_SETUP_BIT];
        end
        `FSS_OFS_PARAM_SEL: begin
          // Parameter selector; codes above six select nothing
          next_st.param_sel = wdata[2:0];
        end
        `FSS_OFS_PARAM_EN: begin
          if (st.param_sel < 3'(`FSS_PARAM_NUM)) begin
            next_st.param_en[st.param_sel] = wdata[0];
          end
        end
        `FSS_OFS_SET_SEL: begin
          next_st.set_sel = wdata[3:0];
        end
        `FSS_OFS_CMD: begin
          // Store copies every slot, restore only the enabled ones
          // Store live set
          if (wdata[`FSS_CMD_STORE_BIT]) begin
            next_st.sets[st.set_sel].vals = st.live;
          end
          if (wdata[`FSS_CMD_RESTORE_BIT]) begin
            next_st.live = apply_set(st.live, st.sets[st.set_sel].vals, st.param_en);
          end
        end
        `FSS_OFS_FIRST_SET: begin
          next_st.first_set = wdata[3:0];
        end
        `FSS_OFS_BRANCH_SEL: begin
          next_st.branch_sel = wdata[0];
        end
        `FSS_OFS_BRANCH_TGT: begin
          next_st.sets[st.set_sel].br[st.branch_sel].target = wdata[3:0];
        end
        `FSS_OFS_BRANCH_SRC: begin
          // Only listed sources accepted
          // Codes above the encoder leave the source unchanged
          if (wdata <= 32'(SRC_ENCODER)) begin
            next_st.sets[st.set_sel].br[st.branch_sel].src = fss_src_e'(wdata[2:0]);
          end
        end
        `FSS_OFS_LIVE_VALUE: begin
          // A transition in the same cycle overrides enabled slots
          if (st.param_sel < 3'(`FSS_PARAM_NUM)) begin
            next_st.live[st.param_sel] = wdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end

    case (st.eng)
      ENG_IDLE: begin
        // Restart after an off phase re-enters the first set
        if (st.engine_on) begin
          next_st.eng = ENG_RUN;
          next_st.live_set = st.first_set;
          next_st.live = apply_set(next_st.live, st.sets[st.first_set].vals, st.param_en);
        end
      end
      ENG_RUN: begin
        if (!st.engine_on) begin
          next_st.eng = ENG_IDLE;
        end else begin
          hit0 = src_fired(b0.src, evt_edge);
          hit1 = src_fired(b1.src, evt_edge);
          // Branch 0 priority
          // Branch 1 only wins while branch 0 stays quiet
          tgt = hit0 ? b0.target : b1.target;
          if (hit0 || hit1) begin
            next_st.live_set = tgt;
            next_st.live = apply_set(next_st.live, st.sets[tgt].vals, st.param_en);
          end
        end
      end
      default: next_st.eng = ENG_IDLE;
    endcase

    // Read data stands only in the cycle after the strobe
    // Unmapped, write-only and refused reads return zero
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `FSS_OFS_CTRL: begin
          next_st.rdata[`FSS_CTRL_ENGINE_BIT] = st.engine_on;
          next_st.rdata[`FSS_CTRL_SETUP_BIT] = st.setup_mode;
        end
        `FSS_OFS_PARAM_SEL: begin
          next_st.rdata = {29'h0, st.param_sel};
        end
        `FSS_OFS_PARAM_EN: begin
          if (st.param_sel < 3'(`FSS_PARAM_NUM)) begin
            next_st.rdata = {31'h0, st.param_en[st.param_sel]};
          end
        end
        `FSS_OFS_SET_SEL: begin
          next_st.rdata = {28'h0, st.set_sel};
        end
        `FSS_OFS_LIVE_SET: begin
          next_st.rdata = {28'h0, st.live_set};
        end
        `FSS_OFS_FIRST_SET: begin
          next_st.rdata = {28'h0, st.first_set};
        end
        `FSS_OFS_BRANCH_SEL: begin
          next_st.rdata = {31'h0, st.branch_sel};
        end
        `FSS_OFS_BRANCH_TGT: begin
          next_st.rdata = {28'h0, st.sets[st.set_sel].br[st.branch_sel].target};
        end
        `FSS_OFS_BRANCH_SRC: begin
          next_st.rdata = {29'h0, st.sets[st.set_sel].br[st.branch_sel].src};
        end
        `FSS_OFS_BRANCH_EDGE: begin
          next_st.rdata = `FSS_EDGE_UP_CODE;
        end
        `FSS_OFS_LIVE_VALUE: begin
          // Selector codes above six read zero
          if (st.param_sel < 3'(`FSS_PARAM_NUM)) begin
            next_st.rdata = {16'h0, st.live[st.param_sel]};
          end
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Reset clears every set, so all branch sources read off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register
  assign rdata = st.rdata;
  assign exposure_length = st.live[PAR_EXPOSURE];
  assign count_unit0_length = st.live[PAR_COUNT0];
  assign roi_horiz_shift = st.live[PAR_ROI_H];
  assign roi_vert_shift = st.live[PAR_ROI_V];
  assign gain = st.live[PAR_GAIN];
  assign lens_drive_current = st.live[PAR_LENS_CUR];
  assign lens_optical_power = st.live[PAR_LENS_PWR];
  assign live_set_index = st.live_set;
  assign seq_engine_on = st.engine_on;
  assign seq_setup_mode = st.setup_mode;

endmodule : fss_sequencer
`default_nettype wire

// file: dv/fss_evt_src.sv
// Camera event source model for the sequencer's event inputs.
// A fire bit raises its line for three clocks; lines idle low.
`timescale 1ns/1ps
`default_nettype none
module fss_evt_src (
  input wire logic clk,
  input wire logic [3:0] fire,
  output logic exposure_done_evt,
  output logic count_unit0_done_evt,
  output logic timer_unit0_done_evt,
  output logic shaft_encoder_evt
);
  logic [3:0] h1 = 4'h0;
  logic [3:0] h2 = 4'h0;
  logic [3:0] h3 = 4'h0;
  always @(posedge clk) begin
    h1 <= fire;
    h2 <= h1;
    h3 <= h2;
  end
  assign {shaft_encoder_evt, timer_unit0_done_evt, count_unit0_done_evt, exposure_done_evt} = h1 | h2 | h3;
endmodule : fss_evt_src
`default_nettype wire

// file: dv/fss_props.sv
// Port assertions of the parameter sequencer.
// Bound to fss_sequencer from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "fss_cfg.svh"
module fss_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`FSS_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic exposure_done_evt,
  input wire logic count_unit0_done_evt,
  input wire logic timer_unit0_done_evt,
  input wire logic shaft_encoder_evt,
  input wire logic [15:0] exposure_length,
  input wire logic [15:0] gain,
  input wire logic [3:0] live_set_index,
  input wire logic seq_engine_on
);
  logic [3:0] evt;
  logic [3:0] evt_q;
  logic [3:0] since_rise;
  assign evt = {shaft_encoder_evt, timer_unit0_done_evt, count_unit0_done_evt, exposure_done_evt};
  // Cycles since the last rising edge on any event line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_q <= 4'h0;
      since_rise <= 4'hf;
    end else begin
      evt_q <= evt;
      if (|(evt & ~evt_q)) since_rise <= 4'h0;
      else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside a read slot");
  live_read_a: assert property (rd && addr == `FSS_OFS_LIVE_SET |=> rdata == {28'h0, $past(live_set_index)})
    else $error("live set read mismatch");
  edge_read_a: assert property (rd && addr == `FSS_OFS_BRANCH_EDGE |=> rdata == `FSS_EDGE_UP_CODE)
    else $error("edge activation not fixed");
  engine_write_a: assert property (wr && addr == `FSS_OFS_CTRL |=> seq_engine_on == $past(wdata[0]))
    else $error("engine switch not written");
  live_hold_off_a: assert property (!seq_engine_on && !wr |=> $stable(live_set_index))
    else $error("set changed while engine off");
  param_hold_off_a: assert property (!seq_engine_on && !wr |=> $stable(exposure_length) && $stable(gain))
    else $error("parameter changed while engine off");
  step_cause_a: assert property ($changed(live_set_index) && $past(seq_engine_on) && $past(seq_engine_on, 2)
    |-> since_rise <= 4'h8)
    else $error("set step without event edge");
  one_step_a: assert property ($changed(live_set_index) && seq_engine_on && $past(seq_engine_on)
    |=> $stable(live_set_index))
    else $error("two steps in a row");
endmodule : fss_props
`default_nettype wire

// file: dv/tb_feature_set_sequencer.sv
// Testbench of the parameter sequencer: register tasks, event steps, checks.
// Assumes fss_sequencer, fss_evt_src and fss_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fss_cfg.svh"
module tb_feature_set_sequencer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] fire = 4'h0;
  logic [31:0] rdata;
  logic [15:0] par [7];
  logic [3:0] live;
  logic eng;
  logic setup;
  int pl[4] = '{2, 3, 5, 6};
  logic e0, e1, e2, e3;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  fss_evt_src src (.clk(clk), .fire(fire), .exposure_done_evt(e0), .count_unit0_done_evt(e1),
    .timer_unit0_done_evt(e2), .shaft_encoder_evt(e3));
  fss_sequencer uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .exposure_done_evt(e0), .count_unit0_done_evt(e1), .timer_unit0_done_evt(e2), .shaft_encoder_evt(e3),
    .exposure_length(par[0]), .count_unit0_length(par[1]), .roi_horiz_shift(par[2]), .roi_vert_shift(par[3]),
    .gain(par[4]), .lens_drive_current(par[5]), .lens_optical_power(par[6]), .live_set_index(live),
    .seq_engine_on(eng), .seq_setup_mode(setup));
  initial forever #12.5 clk = ~clk;
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask : rreg
  // Store exposure and gain values tagged with the set number
  task automatic build(input logic [3:0] s);
    wreg(`FSS_OFS_SET_SEL, {28'h0, s});
    wreg(`FSS_OFS_PARAM_SEL, 32'h0);
    wreg(`FSS_OFS_LIVE_VALUE, 32'h100 + s);
    wreg(`FSS_OFS_PARAM_SEL, 32'h4);
    wreg(`FSS_OFS_LIVE_VALUE, 32'h200 + s);
    wreg(`FSS_OFS_CMD, 32'h1);
  endtask : build
  task automatic br(input logic [3:0] s, input logic b, input logic [3:0] t, input logic [2:0] sr);
    wreg(`FSS_OFS_SET_SEL, {28'h0, s});
    wreg(`FSS_OFS_BRANCH_SEL, {31'h0, b});
    wreg(`FSS_OFS_BRANCH_TGT, {28'h0, t});
    wreg(`FSS_OFS_BRANCH_SRC, {29'h0, sr});
  endtask : br
  // Fire event lines, let the synchroniser settle, check the live set
  task automatic step(input logic [3:0] m, input logic [3:0] s);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("live set", {28'h0, s}, {28'h0, live});
  endtask : step
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`FSS_OFS_CTRL, 32'h0);
    rreg(`FSS_OFS_LIVE_SET, 32'h0);
    rreg(8'h3c, 32'h0);
    wreg(`FSS_OFS_CTRL, 32'h2);
    @(negedge clk);
    chk("setup mode", 32'h1, {31'h0, setup});
    rreg(`FSS_OFS_CTRL, 32'h2);
    wreg(`FSS_OFS_BRANCH_EDGE, 32'h1);
    rreg(`FSS_OFS_BRANCH_EDGE, `FSS_EDGE_UP_CODE);
    wreg(`FSS_OFS_PARAM_SEL, 32'h0);
    wreg(`FSS_OFS_PARAM_EN, 32'h1);
    wreg(`FSS_OFS_PARAM_SEL, 32'h4);
    wreg(`FSS_OFS_PARAM_EN, 32'h1);
    rreg(`FSS_OFS_PARAM_EN, 32'h1);
    // Offsets and lens values stay unsequenced, so no region or lens mode is prepared
    for (int k = 0; k < 4; k++) begin
      wreg(`FSS_OFS_PARAM_SEL, pl[k]);
      wreg(`FSS_OFS_LIVE_VALUE, 32'h300 + pl[k]);
      @(negedge clk);
      chk("live port", 32'h300 + pl[k], {16'h0, par[pl[k]]});
      rreg(`FSS_OFS_LIVE_VALUE, 32'h300 + pl[k]);
    end
    build(4'h2);
    build(4'h5);
    wreg(`FSS_OFS_PARAM_SEL, 32'h1);
    wreg(`FSS_OFS_LIVE_VALUE, 32'h77);
    wreg(`FSS_OFS_SET_SEL, 32'h2);
    wreg(`FSS_OFS_CMD, 32'h2);
    @(negedge clk);
    chk("exposure", 32'h102, {16'h0, par[0]});
    chk("gain", 32'h202, {16'h0, par[4]});
    chk("counter", 32'h77, {16'h0, par[1]});
    // Every set that is visited gets at least one branch
    br(4'h2, 1'b0, 4'h5, 3'h1);
    br(4'h2, 1'b1, 4'h9, 3'h3);
    br(4'h5, 1'b0, 4'h2, 3'h2);
    br(4'h9, 1'b0, 4'h5, 3'h4);
    wreg(`FSS_OFS_PARAM_SEL, 32'h0);
    wreg(`FSS_OFS_LIVE_VALUE, 32'haa);
    wreg(`FSS_OFS_FIRST_SET, 32'h2);
    rreg(`FSS_OFS_FIRST_SET, 32'h2);
    wreg(`FSS_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("live set", 32'h2, {28'h0, live});
    chk("exposure", 32'h102, {16'h0, par[0]});
    step(4'b0101, 4'h5);
    chk("exposure", 32'h105, {16'h0, par[0]});
    step(4'b0001, 4'h5);
    step(4'b0010, 4'h2);
    step(4'b0100, 4'h9);
    step(4'b1000, 4'h5);
    wreg(`FSS_OFS_CTRL, 32'h0);
    step(4'b0010, 4'h5);
    complete_run();
  end
endmodule : tb_feature_set_sequencer
bind fss_sequencer fss_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .exposure_done_evt(exposure_done_evt), .count_unit0_done_evt(count_unit0_done_evt),
  .timer_unit0_done_evt(timer_unit0_done_evt), .shaft_encoder_evt(shaft_encoder_evt),
  .exposure_length(exposure_length), .gain(gain), .live_set_index(live_set_index), .seq_engine_on(seq_engine_on));
`default_nettype wire
